// ==== pdc_controller.sv ====
// Purpose: clock generation controller with pre-divider, vco model, three post-dividers and reset lengthener
// Assumes: aclk is the selected reference clock; awprot/arprot are not used
// Notes:   the vco is a fractional tick accumulator, so all clock outputs stay in the aclk domain
// How it works
// - multiplier accepts x4 to x25; writes outside that range clamp to the edges
// - four dividers take ratios 1 to 32; after internal reset release, a disabled post-divider holds its clock low
// - auxiliary clock carries the reference without any divider after internal reset
// - mode select 1 feeds post-dividers from vco path, 0 from reference directly
// - controller leaves reset in bypass mode with mode select reading 0
// - vco path divides reference by pre-divider then multiplies; pre-divider must be on
// - internal reset stays asserted for 4096 reference cycles after external reset release
// - during internal reset every clock output, aux included, runs at reference over 8
// - end of count releases internal reset, sets stable, dividers start at the ratios then in their registers
// - register defaults are loaded while external reset is held, kept from its release
// - reset leaves mode select 0 and pll reset control 1
// - post-divider ratio writes take effect at an align update, or at internal reset release if written while it is held
// - writing 1 to the trigger bit of the command register starts an align update
// - selected clocks pause low, then restart together on one rising edge at new ratios
// - unselected clocks keep running at old ratios through an align update
// - align in progress reads 1 for the whole update and 0 afterwards
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module pdc_controller #(
  parameter int RST_REF_CYCLES = 4096                   // reference cycles of reset lengthening
) (
  input  wire logic                     aclk,               // reference clock, 250 MHz
  input  wire logic                     aresetn,            // external reset, synchronous, active low
  input  wire pdc_pkg::pdc_axi_req_type axi_req,            // register bus request
  output pdc_pkg::pdc_axi_rsp_type      axi_rsp,            // register bus answer
  output logic                          aux_ref_clock,      // auxiliary reference clock
  output logic                          system_clock_one,   // post-divider one output
  output logic                          system_clock_two,   // post-divider two output
  output logic                          system_clock_three, // post-divider three output
  output logic                          pll_reset_control,  // reset to the analog pll
  output logic                          sys_rst_n           // lengthened internal reset, active low
);

  localparam int RST_ACLK = RST_REF_CYCLES * pdc_pkg::ACLK_PER_REF;
  localparam int RCW      = $clog2(RST_ACLK) + 1;

  // control and status state
  logic                          mode_r;
  logic                          pwrdn_r;
  logic [pdc_pkg::MULT_W-1:0]    mult_r;
  logic [pdc_pkg::RATIO_W-1:0]   div_ratio_r [4];
  logic                          div_en_r    [4];
  logic [pdc_pkg::ALIGN_W-1:0]   align_sel_r;
  logic [pdc_pkg::ALIGN_W-1:0]   go_sel_r;
  logic                          busy_r;
  logic [RCW-1:0]                rst_cnt_r;
  logic [2:0]                    d8_cnt_r;
  logic [10:0]                   acc_r;
  logic [11:0]                   awaddr_r;
  logic [31:0]                   wdata_r;
  logic [3:0]                    wstrb_r;
  logic                          sclk_r      [3];
  logic [pdc_pkg::RATIO_W-1:0]   cnt_r       [3];
  logic [pdc_pkg::RATIO_W-1:0]   act_ratio_r [3];

  // combinational helpers
  logic        wr_fire;
  logic        go_start;
  logic        release_go;
  logic        d8_tick;
  logic        pll_ok;
  logic        tick_pll;
  logic        tick;
  logic [11:0] acc_sum;
  logic [11:0] acc_lim;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [2:0]  sel_low;

  // merge a word with the written byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                         input logic [31:0] m);
    merge = (old_w & ~m) | (new_w & m);
  endfunction

  // write strobe to bit mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_r[b]}};
    end
  end

  // write happens once both address and data are held and the response slot is free
  assign wr_fire  = ~axi_rsp.awready & ~axi_rsp.wready & ~axi_rsp.bvalid;
  assign go_start = wr_fire && (awaddr_r == pdc_pkg::OFS_CMD) && wstrb_r[0] && sys_rst_n
                    && wdata_r[pdc_pkg::CMD_GO_BIT] && !busy_r;
  assign d8_tick  = (d8_cnt_r == pdc_pkg::RST_HALF_LAST);

  // vco model: reference edges times mult over (prediv ratio * 2^frac)
  assign pll_ok   = ~pll_reset_control & ~pwrdn_r & div_en_r[0];
  assign acc_sum  = {1'b0, acc_r} + {7'h00, mult_r};
  assign acc_lim  = 12'({7'h00, div_ratio_r[0]} + 12'h001) << pdc_pkg::VCO_FRAC_W;
  assign tick_pll = pll_ok && (acc_sum >= acc_lim);
  assign tick     = mode_r ? tick_pll : 1'b1;

  // align update completes when every selected clock is paused low
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      sel_low[i] = ~go_sel_r[i] | ~sclk_r[i];
    end
  end
  assign release_go = busy_r && tick && (&sel_low);

  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (axi_req.araddr)
      pdc_pkg::OFS_CSR: begin
        rd_word[pdc_pkg::CSR_MODE_BIT]   = mode_r;
        rd_word[pdc_pkg::CSR_PLL_RESET_CONTROL_BIT] = pll_reset_control;
        rd_word[pdc_pkg::CSR_PWRDN_BIT]  = pwrdn_r;
        rd_word[pdc_pkg::CSR_STABLE_BIT] = sys_rst_n;
      end
      pdc_pkg::OFS_MULT:  rd_word[pdc_pkg::MULT_W-1:0] = mult_r;
      pdc_pkg::OFS_DIV0: begin
        rd_word[pdc_pkg::RATIO_W-1:0]   = div_ratio_r[0];
        rd_word[pdc_pkg::DIV_EN_BIT]    = div_en_r[0];
      end
      pdc_pkg::OFS_DIV1: begin
        rd_word[pdc_pkg::RATIO_W-1:0]   = div_ratio_r[1];
        rd_word[pdc_pkg::DIV_EN_BIT]    = div_en_r[1];
      end
      pdc_pkg::OFS_DIV2: begin
        rd_word[pdc_pkg::RATIO_W-1:0]   = div_ratio_r[2];
        rd_word[pdc_pkg::DIV_EN_BIT]    = div_en_r[2];
      end
      pdc_pkg::OFS_DIV3: begin
        rd_word[pdc_pkg::RATIO_W-1:0]   = div_ratio_r[3];
        rd_word[pdc_pkg::DIV_EN_BIT]    = div_en_r[3];
      end
      pdc_pkg::OFS_CMD:   rd_word = 32'h0000_0000;
      pdc_pkg::OFS_STAT:  rd_word[pdc_pkg::STAT_BUSY_BIT] = busy_r;
      pdc_pkg::OFS_ALIGN: rd_word[pdc_pkg::ALIGN_W-1:0] = align_sel_r;
      default:            rd_hit = 1'b0;
    endcase
  end

  // write channels: address and data are taken in either order and held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axi_rsp.awready <= 1'b1;
      axi_rsp.wready  <= 1'b1;
      axi_rsp.bvalid  <= 1'b0;
      axi_rsp.bresp   <= pdc_pkg::RESP_OKAY;
      awaddr_r        <= 12'h000;
      wdata_r         <= 32'h0000_0000;
      wstrb_r         <= 4'h0;
    end else begin
      if (axi_req.awvalid && axi_rsp.awready) begin
        awaddr_r        <= axi_req.awaddr;
        axi_rsp.awready <= 1'b0;
      end else if (wr_fire) begin
        axi_rsp.awready <= 1'b1;
      end
      if (axi_req.wvalid && axi_rsp.wready) begin
        wdata_r        <= axi_req.wdata;
        wstrb_r        <= axi_req.wstrb;
        axi_rsp.wready <= 1'b0;
      end else if (wr_fire) begin
        axi_rsp.wready <= 1'b1;
      end
      if (wr_fire) begin
        axi_rsp.bvalid <= 1'b1;
        case (awaddr_r)
          pdc_pkg::OFS_CSR, pdc_pkg::OFS_MULT, pdc_pkg::OFS_DIV0, pdc_pkg::OFS_DIV1, pdc_pkg::OFS_DIV2,
          pdc_pkg::OFS_DIV3, pdc_pkg::OFS_CMD, pdc_pkg::OFS_STAT, pdc_pkg::OFS_ALIGN:
            axi_rsp.bresp <= pdc_pkg::RESP_OKAY;
          default: axi_rsp.bresp <= pdc_pkg::RESP_SLVERR;
        endcase
      end else if (axi_rsp.bvalid && axi_req.bready) begin
        axi_rsp.bvalid <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axi_rsp.arready <= 1'b1;
      axi_rsp.rvalid  <= 1'b0;
      axi_rsp.rdata   <= 32'h0000_0000;
      axi_rsp.rresp   <= pdc_pkg::RESP_OKAY;
    end else if (axi_req.arvalid && axi_rsp.arready) begin
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid  <= 1'b1;
      axi_rsp.rdata   <= rd_word;
      axi_rsp.rresp   <= rd_hit ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
    end else if (axi_rsp.rvalid && axi_req.rready) begin
      axi_rsp.rvalid  <= 1'b0;
      axi_rsp.arready <= 1'b1;
    end
  end

  // control registers; defaults load under external reset and hold from its release
  always_ff @(posedge aclk) begin
    logic [31:0] nw;
    nw = 32'h0000_0000;
    if (!aresetn) begin
      mode_r            <= pdc_pkg::CSR_MODE_RST;
      pll_reset_control <= pdc_pkg::CSR_PLL_RESET_CONTROL_RST;
      pwrdn_r           <= pdc_pkg::CSR_PWRDN_RST;
      mult_r            <= pdc_pkg::MULT_RST;
      align_sel_r       <= pdc_pkg::ALIGN_RST;
      for (int d = 0; d < 4; d++) begin
        div_ratio_r[d] <= pdc_pkg::DIV_RATIO_RST[d];
        div_en_r[d]    <= pdc_pkg::DIV_EN_RST[d];
      end
    end else if (wr_fire) begin
      case (awaddr_r)
        pdc_pkg::OFS_CSR: begin
          nw = merge({27'h0, pwrdn_r, pll_reset_control, 2'h0, mode_r}, wdata_r, wmask);
          mode_r            <= nw[pdc_pkg::CSR_MODE_BIT];
          pll_reset_control <= nw[pdc_pkg::CSR_PLL_RESET_CONTROL_BIT];
          pwrdn_r           <= nw[pdc_pkg::CSR_PWRDN_BIT];
        end
        pdc_pkg::OFS_MULT: begin
          nw = merge({27'h0, mult_r}, wdata_r, wmask);
          if (nw[pdc_pkg::MULT_W-1:0] < pdc_pkg::MULT_MIN) mult_r <= pdc_pkg::MULT_MIN;
          else if (nw[pdc_pkg::MULT_W-1:0] > pdc_pkg::MULT_MAX) mult_r <= pdc_pkg::MULT_MAX;
          else mult_r <= nw[pdc_pkg::MULT_W-1:0];
        end
        pdc_pkg::OFS_DIV0, pdc_pkg::OFS_DIV1, pdc_pkg::OFS_DIV2, pdc_pkg::OFS_DIV3: begin
          for (int d = 0; d < 4; d++) begin
            if (awaddr_r == pdc_pkg::OFS_DIV0 + 12'(4 * d)) begin
              nw = merge({16'h0, div_en_r[d], 10'h0, div_ratio_r[d]}, wdata_r, wmask);
              div_ratio_r[d] <= nw[pdc_pkg::RATIO_W-1:0];
              div_en_r[d]    <= nw[pdc_pkg::DIV_EN_BIT];
            end
          end
        end
        pdc_pkg::OFS_ALIGN: begin
          nw = merge({29'h0, align_sel_r}, wdata_r, wmask);
          align_sel_r <= nw[pdc_pkg::ALIGN_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // reset lengthener and the fixed divide-by-8 phase counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_r <= '0;
      sys_rst_n <= 1'b0;
      d8_cnt_r  <= 3'h0;
    end else begin
      d8_cnt_r <= d8_cnt_r + 3'h1;
      if (!sys_rst_n) begin
        if (rst_cnt_r == RCW'(RST_ACLK - 1)) sys_rst_n <= 1'b1;
        else rst_cnt_r <= rst_cnt_r + RCW'(1);
      end
    end
  end

  // vco phase accumulator; cleared while the pll is held or the pre-divider is off
  always_ff @(posedge aclk) begin
    if (!aresetn || !pll_ok) acc_r <= 11'h000;
    else if (tick_pll) acc_r <= 11'(acc_sum - acc_lim);
    else acc_r <= acc_sum[10:0];
  end

  // align update status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r   <= 1'b0;
      go_sel_r <= 3'h0;
    end else if (go_start) begin
      busy_r   <= 1'b1;
      go_sel_r <= align_sel_r;
    end else if (release_go) begin
      busy_r   <= 1'b0;
    end
  end

  // auxiliary clock: reference after internal reset, reference over 8 before
  always_ff @(posedge aclk) begin
    if (!aresetn) aux_ref_clock <= 1'b0;
    else if (!sys_rst_n) aux_ref_clock <= d8_tick ? ~aux_ref_clock : aux_ref_clock;
    else aux_ref_clock <= ~aux_ref_clock;
  end

  // three post-dividers
  for (genvar i = 0; i < 3; i++) begin : g_post
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sclk_r[i]      <= 1'b0;
        cnt_r[i]       <= '0;
        act_ratio_r[i] <= pdc_pkg::DIV_RATIO_RST[i+1];
      end else if (!sys_rst_n) begin
        sclk_r[i]      <= d8_tick ? ~sclk_r[i] : sclk_r[i];
        cnt_r[i]       <= '0;
        act_ratio_r[i] <= div_ratio_r[i+1];
      end else if (!div_en_r[i+1]) begin
        sclk_r[i] <= 1'b0;
        cnt_r[i]  <= '0;
      end else if (release_go && go_sel_r[i]) begin
        sclk_r[i]      <= 1'b1;
        cnt_r[i]       <= '0;
        act_ratio_r[i] <= div_ratio_r[i+1];
      end else if (tick && !(busy_r && go_sel_r[i] && !sclk_r[i])) begin
        if (cnt_r[i] == act_ratio_r[i]) begin
          cnt_r[i]  <= '0;
          sclk_r[i] <= ~sclk_r[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + 5'h01;
        end
      end
    end
  end

  // post-divider outputs
  assign system_clock_one   = sclk_r[0];
  assign system_clock_two   = sclk_r[1];
  assign system_clock_three = sclk_r[2];

endmodule // pdc_controller

// ==== pdc_pkg.sv ====
// Purpose: shared constants and carrier types of the clock generation controller
// Assumes: registers sit on an AXI4-Lite slave with 32-bit data, decoded on 12 address bits
// Notes:   the reference clock is aclk itself; an output clock is a flop that toggles on edge ticks
package pdc_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CSR    = 12'h100;
  localparam logic [11:0] OFS_MULT   = 12'h110;
  localparam logic [11:0] OFS_DIV0   = 12'h114;
  localparam logic [11:0] OFS_DIV1   = 12'h118;
  localparam logic [11:0] OFS_DIV2   = 12'h11c;
  localparam logic [11:0] OFS_DIV3   = 12'h120;
  localparam logic [11:0] OFS_CMD    = 12'h138;
  localparam logic [11:0] OFS_STAT   = 12'h13c;
  localparam logic [11:0] OFS_ALIGN  = 12'h140;

  // control/status register fields
  localparam int CSR_MODE_BIT   = 0;
  localparam int CSR_PLL_RESET_CONTROL_BIT = 3;
  localparam int CSR_PWRDN_BIT  = 4;
  localparam int CSR_STABLE_BIT = 6;
  localparam logic CSR_MODE_RST   = 1'b0;
  localparam logic CSR_PLL_RESET_CONTROL_RST = 1'b1;
  localparam logic CSR_PWRDN_RST  = 1'b1;

  // multiplier and divider fields
  localparam int MULT_W     = 5;
  localparam logic [4:0] MULT_MIN = 5'h04;
  localparam logic [4:0] MULT_MAX = 5'h19;
  localparam logic [4:0] MULT_RST = 5'h04;
  localparam int RATIO_W    = 5;
  localparam int DIV_EN_BIT = 15;
  localparam logic [4:0] DIV_RATIO_RST [4] = '{5'h00, 5'h00, 5'h01, 5'h02};
  localparam logic       DIV_EN_RST    [4] = '{1'b1, 1'b1, 1'b1, 1'b1};

  // command, status and align fields
  localparam int CMD_GO_BIT    = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int ALIGN_W       = 3;
  localparam logic [2:0] ALIGN_RST = 3'h0;

  // timing: aclk cycles per reference cycle, reset-time divide, vco fraction bits
  localparam int ACLK_PER_REF  = 2;
  localparam logic [2:0] RST_HALF_LAST = 3'h7;
  localparam int VCO_FRAC_W    = 5;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // bus request from the master
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } pdc_axi_req_type;

  // bus answer from this slave
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pdc_axi_rsp_type;

endpackage

// ==== pdc_clk_watch.sv ====
// Purpose: clock consumer model that measures high and low widths of one output clock
// Assumes: the watched clock is a registered output of the aclk domain
// Notes:   widths are counted in aclk cycles; clr wipes old results so a stalled clock cannot pass
`timescale 1ns/1ps
module pdc_clk_watch (
  input  wire logic        aclk,   // sampling clock
  input  wire logic        clr,    // clears the last widths
  input  wire logic        clk_in, // watched clock
  output logic      [15:0] hi_w,   // last high width
  output logic      [15:0] lo_w    // last low width
);
  logic [15:0] cnt_r;
  logic        prev_r;

  // count samples of one level, store the count when the level changes
  always_ff @(posedge aclk) begin
    prev_r <= clk_in;
    if (clr) begin
      hi_w  <= 16'h0;
      lo_w  <= 16'h0;
      cnt_r <= 16'h1;
    end else if (clk_in != prev_r) begin
      if (prev_r) hi_w <= cnt_r;
      else lo_w <= cnt_r;
      cnt_r <= 16'h1;
    end else begin
      cnt_r <= cnt_r + 16'h1;
    end
  end
endmodule // pdc_clk_watch

// ==== pdc_assertions.sv ====
// Purpose: checker of reset lengthening, reset-time clocks and bus answer timing
// Assumes: sees only the controller ports; one clock domain
// Notes:   bound to every controller instance at the foot of this file
`timescale 1ns/1ps
module pdc_assertions #(
  parameter int RST_REF_CYCLES = 4096 // reference cycles of reset lengthening
) (
  input wire logic                     aclk,               // reference clock
  input wire logic                     aresetn,            // external reset
  input wire pdc_pkg::pdc_axi_req_type axi_req,            // bus request
  input wire pdc_pkg::pdc_axi_rsp_type axi_rsp,            // bus answer
  input wire logic                     aux_ref_clock,      // auxiliary clock
  input wire logic                     system_clock_one,   // post-divider one
  input wire logic                     system_clock_two,   // post-divider two
  input wire logic                     system_clock_three, // post-divider three
  input wire logic                     pll_reset_control,  // pll reset
  input wire logic                     sys_rst_n           // internal reset
);
  localparam int LIM = 2 * RST_REF_CYCLES;
  logic [15:0] cnt_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // edges since release while the internal reset is still held
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_r <= 16'h0;
    else if (!sys_rst_n) cnt_r <= cnt_r + 16'h1;
  end

  sequence slow_tog;
    $changed(aux_ref_clock) && !sys_rst_n;
  endsequence
  sequence wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence

  rst_len_a: assert property ($rose(sys_rst_n) |-> cnt_r >= LIM - 1 && cnt_r <= LIM + 1)
    else $error("internal reset released at wrong count");
  rst_late_a: assert property (!sys_rst_n |-> cnt_r <= LIM + 1)
    else $error("internal reset held too long");
  rst_div8_a: assert property (slow_tog |=> ($stable(aux_ref_clock) || sys_rst_n)[*7]
    ##1 ($changed(aux_ref_clock) || sys_rst_n))
    else $error("reset-time clock not toggling every 8 cycles");
  rst_same_a: assert property (!sys_rst_n |-> system_clock_one == aux_ref_clock
    && system_clock_two == aux_ref_clock && system_clock_three == aux_ref_clock)
    else $error("reset-time clocks differ");
  aux_ref_a: assert property (sys_rst_n [*3] |-> $changed(aux_ref_clock))
    else $error("auxiliary clock not following reference");
  pll_reset_control_dflt_a: assert property ($rose(aresetn) |-> pll_reset_control)
    else $error("pll reset control not set after reset");
  wr_resp_a: assert property (wr_take |-> ##2 axi_rsp.bvalid)
    else $error("write response late");
  bdone_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response repeated");
  rd_resp_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data late");
  rdone_a: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
    else $error("read data repeated");
endmodule // pdc_assertions

bind pdc_controller pdc_assertions #(.RST_REF_CYCLES(RST_REF_CYCLES)) u_pdc_assertions (
  .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .aux_ref_clock(aux_ref_clock), .system_clock_one(system_clock_one),
  .system_clock_two(system_clock_two), .system_clock_three(system_clock_three),
  .pll_reset_control(pll_reset_control), .sys_rst_n(sys_rst_n));

// ==== tb.sv ====
// Purpose: register-driven test of the clock generation controller
// Assumes: reset lengthening shortened to 64 reference cycles
// Notes:   clock widths are measured by four consumer models
`timescale 1ns/1ps
module tb;
  localparam int         RSTC = 64;
  localparam logic [1:0] OK   = pdc_pkg::RESP_OKAY;
  localparam logic [1:0] SE   = pdc_pkg::RESP_SLVERR;
  logic                     aclk, aresetn, clr;
  pdc_pkg::pdc_axi_req_type axi_req;
  pdc_pkg::pdc_axi_rsp_type axi_rsp;
  logic                     aux_ref_clock, system_clock_one, system_clock_two, system_clock_three;
  logic                     pll_reset_control, sys_rst_n;
  logic [63:0]              hi_all, lo_all;
  int                       miscompares, n_checks;

  pdc_controller #(.RST_REF_CYCLES(RSTC)) u_pdc_controller (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .aux_ref_clock(aux_ref_clock),
    .system_clock_one(system_clock_one), .system_clock_two(system_clock_two),
    .system_clock_three(system_clock_three), .pll_reset_control(pll_reset_control), .sys_rst_n(sys_rst_n));
  pdc_clk_watch u_pdc_clk_watch [3:0] (.aclk(aclk), .clr(clr),
    .clk_in({system_clock_three, system_clock_two, system_clock_one, aux_ref_clock}),
    .hi_w(hi_all), .lo_w(lo_all));

  // 250 MHz clock
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // bus master: only this cpu-side path touches the registers
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    do begin
      @(posedge aclk);
      aw = aw | axi_rsp.awready;
      w = w | axi_rsp.wready;
      if (aw) axi_req.awvalid <= 1'b0;
      if (w) axi_req.wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge aclk); while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
    chk(32'(axi_rsp.bresp), 32'(er));
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do @(posedge aclk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    do @(posedge aclk); while (axi_rsp.rvalid !== 1'b1);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask

  // wait for the align update to finish
  task automatic poll();
    logic [31:0] d;
    logic [1:0]  r;
    d = 32'h1;
    while (d[0] !== 1'b0) rd(pdc_pkg::OFS_STAT, d, r);
    chk(d, 32'h0);
  endtask

  // measure clock i over 5*e+4 cycles against half width e
  task automatic ms(input int i, input logic [15:0] e);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (5 * e + 4) @(posedge aclk);
    chk(32'(hi_all[16*i +: 16]), 32'(e));
    chk(32'(lo_all[16*i +: 16]), 32'(e));
  endtask

  // watchdog
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    final_report();
  end

  // main sequence
  initial begin
    aresetn = 1'b0;
    clr = 1'b1;
    axi_req = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc(pdc_pkg::OFS_CSR, 32'h18, OK);
    ms(0, 16'h8);
    ms(1, 16'h8);
    while (sys_rst_n !== 1'b1) @(posedge aclk);
    rc(pdc_pkg::OFS_CSR, 32'h58, OK);
    rc(pdc_pkg::OFS_DIV1, 32'h8000, OK);
    rc(pdc_pkg::OFS_DIV2, 32'h8001, OK);
    rc(pdc_pkg::OFS_DIV3, 32'h8002, OK);
    rc(pdc_pkg::OFS_STAT, 32'h0, OK);
    ms(0, 16'h1);
    ms(1, 16'h1);
    ms(2, 16'h2);
    ms(3, 16'h3);
    rc(12'h104, 32'h0, SE);
    wr(12'h104, 32'h1, SE);
    wr(pdc_pkg::OFS_MULT, 32'h0, OK);
    rc(pdc_pkg::OFS_MULT, 32'h4, OK);
    wr(pdc_pkg::OFS_MULT, 32'h1f, OK);
    rc(pdc_pkg::OFS_MULT, 32'h19, OK);
    // bypass: widest ratio on clock two, clock one left out of the update
    wr(pdc_pkg::OFS_DIV2, 32'h801f, OK);
    wr(pdc_pkg::OFS_DIV1, 32'h8002, OK);
    ms(2, 16'h2);
    wr(pdc_pkg::OFS_ALIGN, 32'h2, OK);
    wr(pdc_pkg::OFS_CMD, 32'h1, OK);
    poll();
    chk(32'(system_clock_two), 32'h1);
    ms(2, 16'h20);
    ms(1, 16'h1);
    wr(pdc_pkg::OFS_DIV3, 32'h2, OK);
    repeat (8) @(posedge aclk);
    repeat (16) begin
      @(posedge aclk);
      chk(32'(system_clock_three), 32'h0);
    end
    wr(pdc_pkg::OFS_DIV3, 32'h8002, OK);
    // enter pll mode: tick every 32*(31+1)/4 = 256 cycles
    wr(pdc_pkg::OFS_DIV0, 32'h801f, OK);
    wr(pdc_pkg::OFS_MULT, 32'h4, OK);
    repeat (16) @(posedge aclk);
    wr(pdc_pkg::OFS_CSR, 32'h0, OK);
    chk(32'(pll_reset_control), 32'h0);
    repeat (32) @(posedge aclk);
    wr(pdc_pkg::OFS_CSR, 32'h1, OK);
    rc(pdc_pkg::OFS_CSR, 32'h41, OK);
    ms(1, 16'h100);
    wr(pdc_pkg::OFS_DIV1, 32'h8001, OK);
    wr(pdc_pkg::OFS_DIV2, 32'h8000, OK);
    wr(pdc_pkg::OFS_ALIGN, 32'h7, OK);
    wr(pdc_pkg::OFS_CMD, 32'h1, OK);
    rc(pdc_pkg::OFS_STAT, 32'h1, OK);
    wr(pdc_pkg::OFS_CMD, 32'h1, OK);
    rc(pdc_pkg::OFS_CMD, 32'h0, OK);
    poll();
    chk(32'({system_clock_three, system_clock_two, system_clock_one}), 32'h7);
    ms(1, 16'h200);
    ms(2, 16'h100);
    final_report();
  end
endmodule // tb
